/* File: tb/ieg_far_model.sv */
`default_nettype none
`include "ieg_regs.svh"
module ieg_far_model
	import ieg_pkg::*;
#(
	parameter int PIPE = 3,
	parameter int BUSY = 6
)(
	// clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	// bench requests
	input  wire logic                 idle_req_i,
	input  wire logic                 wake_i,
	input  wire logic [`IEG_NMOD-1:0] kick_i,
	// activity
	output logic                      pipeline_stopped_o,
	output logic [`IEG_NMOD-1:0]      busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int                   pipe_r;
	int                   busy_r;
	logic [`IEG_NMOD-1:0] mask_r;
	// pipeline drains a few cycles after the request
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || wake_i) pipe_r <= 0;
		else if (idle_req_i) pipe_r <= PIPE;
		else if (pipe_r > 1) pipe_r <= pipe_r - 1;
	end
	// transfers always end on their own
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) busy_r <= 0;
		else if (|kick_i) busy_r <= BUSY;
		else if (busy_r > 0) busy_r <= busy_r - 1;
		if (|kick_i) mask_r <= kick_i;
	end
	assign pipeline_stopped_o = (pipe_r == 1);
	assign busy_o = (busy_r > 0) ? mask_r : `IEG_ZERO16;
endmodule : ieg_far_model
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
`include "ieg_regs.svh"
module testbench
	import ieg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_n = 0, instr = 0, wake = 0, stopped, active;
	logic [15:0] ctrl = '0, kick = '0, busy, status, ack, gate;
	ieg_bsp_t    bsp = '0;
	int          fails = 0, n_tests = 0;
	always #25 clk = ~clk;
	ieg_idle_gating u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .idle_instr_i(instr),
		.wake_i(wake), .idle_control_reg_i(ctrl), .pipeline_stopped_i(stopped),
		.busy_i(busy), .bsp_i(bsp), .idle_status_reg_o(status), .idle_ack_o(ack),
		.clk_gate_o(gate), .idle_active_o(active));
	ieg_far_model u_far (.core_clk_i(clk), .rst_n_i(rst_n), .idle_req_i(instr),
		.wake_i(wake), .kick_i(kick), .pipeline_stopped_o(stopped), .busy_o(busy));
	task stop_test;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	// issue idle, leaves us one cycle after entering drain
	task go(input logic [15:0] c);
		ctrl = c;
		instr = 1;
		tick(1);
		instr = 0;
		chk(status, c);
		tick(1);
	endtask : go
	task wait_ack(input logic [15:0] m);
		int i;
		for (i = 0; i < 50 && (ack & m) !== m; i++) tick(1);
		chk(ack & m, m);
		if ((ack & m) !== m) stop_test();
	endtask : wait_ack
	task wake_up(input string name);
		wake = 1;
		ctrl = '0;
		tick(1);
		wake = 0;
		chk(ack | gate | status | {15'h0, active}, '0);
		$display("%s done", name);
	endtask : wake_up
	task t_host;
		kick = 16'h0008;
		go(16'h0008);
		kick = '0;
		chk(ack, 16'h0008);
		tick(1);
		chk(gate, 16'h0008);
		chk({15'h0, active}, 16'h0001);
		wake_up("t_host");
	endtask : t_host
	task t_immediate;
		kick = 16'h07c0;
		tick(1);
		kick = '0;
		go(16'h07c0);
		chk(ack, 16'h07c0);
		wake_up("t_immediate");
	endtask : t_immediate
	task t_wait;
		kick = 16'hc014;
		tick(1);
		kick = '0;
		go(16'hc034);
		chk(ack, '0);
		wait_ack(16'hc034);
		chk(busy & 16'hc014, '0);
		wake_up("t_wait");
	endtask : t_wait
	task t_cpu;
		go(16'h0003);
		chk(ack, '0);
		wait_ack(16'h0001);
		chk({15'h0, stopped}, 16'h0001);
		chk(ack, 16'h0001);
		tick(1);
		chk(ack, 16'h0003);
		wake_up("t_cpu");
	endtask : t_cpu
	task t_bsp;
		bsp.ext_clk = 3'h1;
		bsp.transmitter_reset_n = 3'h4;
		kick = 16'h0800;
		tick(1);
		kick = '0;
		go(16'h3800);
		chk(ack, 16'h1000);
		wait_ack(16'h0800);
		tick(3);
		chk(ack, 16'h1800);
		chk({15'h0, active}, '0);
		wake_up("t_bsp");
	endtask : t_bsp
	task t_auto;
		bsp.transmitter_reset_n = 3'h0;
		go(16'h0804);
		chk(ack, 16'h0804);
		tick(1);
		chk(gate, 16'h0804);
		bsp.dma_req = 3'h1;
		tick(1);
		chk(ack, '0);
		chk(gate, '0);
		bsp.dma_req = 3'h0;
		wait_ack(16'h0804);
		bsp.dma_req = 3'h2;
		tick(1);
		chk(ack, 16'h0800);
		bsp.dma_req = 3'h0;
		wait_ack(16'h0804);
		wake_up("t_auto");
	endtask : t_auto
	task t_bsp_rx;
		bsp = '0;
		bsp.receiver_reset_n = 3'h2;
		go(16'h1000);
		tick(2);
		chk(ack, '0);
		chk({15'h0, active}, '0);
		bsp.receiver_reset_n = 3'h0;
		tick(1);
		chk(ack, 16'h1000);
		wake_up("t_bsp_rx");
	endtask : t_bsp_rx
	task t_reset;
		kick = 16'h0004;
		go(16'h0005);
		kick = '0;
		rst_n = 0;
		tick(2);
		chk(ack | gate | status | {15'h0, active}, '0);
		rst_n = 1;
		ctrl = 16'h0008;
		instr = 1;
		tick(1);
		instr = 0;
		chk(status, 16'h0008);
		tick(1);
		chk(ack, 16'h0008);
		wake_up("t_reset");
	endtask : t_reset
	initial begin
		tick(2);
		rst_n = 1;
		t_host();
		t_immediate();
		t_wait();
		t_cpu();
		t_bsp();
		t_auto();
		t_bsp_rx();
		t_reset();
		stop_test();
	end
endmodule : testbench
`default_nettype wire

/* File: verilog/ieg_idle_gating.sv */
// Overview of operation
// - only modules selected in the captured control idle; others keep clocks
// - core clock gates only after its pipeline has fully stopped
// - core-side controllers and config registers idle only after the core stops
// - dma finishes its current transfer, else idles immediately
// - dma wakes temporarily during idle for serial-port transfers, then re-idles
// - host port idles immediately; software guarantees no host access
// - cache finishes current fill or fetch, else idles at once
// - timers, watchdog, tick timer, gpio ports idle immediately
// - external-clocked serial port finishes current activity, else idles at once
// - idle serial port wakes for dma exchange then returns to idle
// - internal-clocked serial port idles only with both halves held in reset
// - internal-clocked serial port refuses idle while either half is active
// - i2c finishes current bus activity, else idles at once
// - uart finishes current activity, else idles at once
// - idle instruction copies idle control into idle status, driving gating
// - memory interface idles after dma has idled, else immediately
`default_nettype none
`include "ieg_regs.svh"
module ieg_idle_gating
	import ieg_pkg::*;
(
	// clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	// idle request and control
	input  wire logic                 idle_instr_i,
	input  wire logic                 wake_i,
	input  wire logic [`IEG_NMOD-1:0] idle_control_reg_i,
	// module activity
	input  wire logic                 pipeline_stopped_i,
	input  wire logic [`IEG_NMOD-1:0] busy_i,
	input  wire ieg_bsp_t             bsp_i,
	// status and gating
	output logic [`IEG_NMOD-1:0]      idle_status_reg_o,
	output logic [`IEG_NMOD-1:0]      idle_ack_o,
	output logic [`IEG_NMOD-1:0]      clk_gate_o,
	output logic                      idle_active_o
);

	ieg_state_t           state_r;
	logic [`IEG_NMOD-1:0] status_r;
	logic [`IEG_NMOD-1:0] ack_r;
	logic [`IEG_NMOD-1:0] gate_r;
	logic [`IEG_NMOD-1:0] ack_nxt;
	logic [`IEG_NMOD-1:0] gate_nxt;
	logic [`IEG_NMOD-1:0] ready;
	logic [`IEG_NMOD-1:0] immed;
	logic [`IEG_NBSP-1:0] bsp_ok;
	logic                 core_stop;

	// serial port may idle at all
	function automatic logic bsp_allowed(input logic ext, input logic tx_n, input logic rx_n);
		bsp_allowed = ext | (~tx_n & ~rx_n);
	endfunction : bsp_allowed

	assign core_stop = ack_r[`IEG_M_CPU];

	genvar gi;
	generate
		for (gi = 0; gi < `IEG_NBSP; gi = gi + 1) begin : g_bsp
			assign bsp_ok[gi] = bsp_allowed(bsp_i.ext_clk[gi],
				bsp_i.transmitter_reset_n[gi], bsp_i.receiver_reset_n[gi]);
		end
	endgenerate

	// modules that ignore activity
	always_comb begin
		immed = `IEG_ZERO16;
		immed[`IEG_M_HPI]    = 1'b1;
		immed[`IEG_M_TIMER]  = 1'b1;
		immed[`IEG_M_WDOG]   = 1'b1;
		immed[`IEG_M_OSTICK] = 1'b1;
		immed[`IEG_M_GPIO]   = 1'b1;
		immed[`IEG_M_PGPIO]  = 1'b1;
	end

	// per-module entry condition
	always_comb begin
		ready = immed | ~busy_i;
		ready[`IEG_M_CPU]    = pipeline_stopped_i;
		ready[`IEG_M_CPUREG] = core_stop;
		ready[`IEG_M_EXTERNAL_MEMORY_INTERFACE]   = ~busy_i[`IEG_M_DMA] | ack_r[`IEG_M_DMA];
		ready[`IEG_M_DMA]    = ~busy_i[`IEG_M_DMA];
		ready[`IEG_M_BSP0]   = ready[`IEG_M_BSP0] & bsp_ok[0];
		ready[`IEG_M_BSP1]   = ready[`IEG_M_BSP1] & bsp_ok[1];
		ready[`IEG_M_BSP2]   = ready[`IEG_M_BSP2] & bsp_ok[2];
	end

	// idle sequencing state
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_r <= IEG_RUN;
		end else begin
			case (state_r)
				IEG_RUN: begin
					if (idle_instr_i && idle_control_reg_i != `IEG_ZERO16) begin
						state_r <= IEG_DRAIN;
					end
				end
				IEG_DRAIN: begin
					if (wake_i) begin
						state_r <= IEG_RUN;
					end else if (ack_nxt == status_r) begin
						state_r <= IEG_IDLE;
					end
				end
				IEG_IDLE: begin
					if (wake_i) begin
						state_r <= IEG_RUN;
					end
				end
				default: begin
					state_r <= IEG_RUN;
				end
			endcase
		end
	end

	// status capture on idle instruction
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			status_r <= `IEG_ZERO16;
		end else if (wake_i) begin
			status_r <= `IEG_ZERO16;
		end else if (idle_instr_i && state_r == IEG_RUN) begin
			status_r <= idle_control_reg_i;
		end
	end

	// acknowledge and gate, sticky once entered except auto-wake ports
	always_comb begin
		ack_nxt  = ack_r;
		gate_nxt = gate_r;
		if (state_r != IEG_RUN) begin
			ack_nxt = (ack_r | ready) & status_r;
			// dma and serial ports reopen while they move data
			ack_nxt[`IEG_M_DMA] = status_r[`IEG_M_DMA] & ready[`IEG_M_DMA] &
				~(|bsp_i.dma_req);
			ack_nxt[`IEG_M_BSP0] = status_r[`IEG_M_BSP0] & ready[`IEG_M_BSP0] &
				~bsp_i.dma_req[0];
			ack_nxt[`IEG_M_BSP1] = status_r[`IEG_M_BSP1] & ready[`IEG_M_BSP1] &
				~bsp_i.dma_req[1];
			ack_nxt[`IEG_M_BSP2] = status_r[`IEG_M_BSP2] & ready[`IEG_M_BSP2] &
				~bsp_i.dma_req[2];
			gate_nxt = ack_r & ack_nxt;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || wake_i || state_r == IEG_RUN) begin
			ack_r  <= `IEG_ZERO16;
			gate_r <= `IEG_ZERO16;
		end else begin
			ack_r  <= ack_nxt;
			gate_r <= gate_nxt;
		end
	end

	// registered outputs
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			idle_active_o <= 1'b0;
		end else begin
			idle_active_o <= (state_r == IEG_IDLE) && !wake_i;
		end
	end

	assign idle_status_reg_o = status_r;
	assign idle_ack_o        = ack_r;
	assign clk_gate_o        = gate_r;

	// assertions
	property p_gate_after_ack;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(clk_gate_o[`IEG_M_CPU]) |-> $past(idle_ack_o[`IEG_M_CPU]);
	endproperty
	a_gate_after_ack: assert property (p_gate_after_ack) else $error("gate before ack");

	property p_unsel_open;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		|(clk_gate_o & ~idle_status_reg_o) == 1'b0;
	endproperty
	a_unsel_open: assert property (p_unsel_open) else $error("unselected gated");

	property p_cpu_pipe;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(idle_ack_o[`IEG_M_CPU]) |-> $past(pipeline_stopped_i);
	endproperty
	a_cpu_pipe: assert property (p_cpu_pipe) else $error("cpu ack before stop");

	property p_reg_after_cpu;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(idle_ack_o[`IEG_M_CPUREG]) |-> $past(idle_ack_o[`IEG_M_CPU]);
	endproperty
	a_reg_after_cpu: assert property (p_reg_after_cpu) else $error("cpu regs early");

	sequence s_capture;
		idle_instr_i && state_r == IEG_RUN && !wake_i;
	endsequence
	property p_capture;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_capture |=> idle_status_reg_o == $past(idle_control_reg_i);
	endproperty
	a_capture: assert property (p_capture) else $error("status not captured");

	property p_hpi_now;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(state_r == IEG_DRAIN && idle_status_reg_o[`IEG_M_HPI] && !wake_i)
			|=> idle_ack_o[`IEG_M_HPI];
	endproperty
	a_hpi_now: assert property (p_hpi_now) else $error("host port late");

	property p_timer_now;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(state_r == IEG_DRAIN && idle_status_reg_o[`IEG_M_WDOG] && !wake_i)
			|=> idle_ack_o[`IEG_M_WDOG];
	endproperty
	a_timer_now: assert property (p_timer_now) else $error("watchdog late");

	property p_bsp_refuse;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!bsp_i.ext_clk[0] && bsp_i.transmitter_reset_n[0]) |=>
			!$rose(idle_ack_o[`IEG_M_BSP0]);
	endproperty
	a_bsp_refuse: assert property (p_bsp_refuse) else $error("serial port idled");

	property p_dma_busy;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		busy_i[`IEG_M_DMA] |=> !idle_ack_o[`IEG_M_DMA];
	endproperty
	a_dma_busy: assert property (p_dma_busy) else $error("dma idled busy");

	property p_external_memory_interface_dma;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(idle_ack_o[`IEG_M_EXTERNAL_MEMORY_INTERFACE]) |-> $past(!busy_i[`IEG_M_DMA] || idle_ack_o[`IEG_M_DMA]);
	endproperty
	a_external_memory_interface_dma: assert property (p_external_memory_interface_dma) else $error("external_memory_interface early");

	sequence s_draining;
		state_r != IEG_RUN && !wake_i;
	endsequence

	property p_gate_follow;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(clk_gate_o & ~(idle_ack_o & $past(idle_ack_o))) == `IEG_ZERO16;
	endproperty
	a_gate_follow: assert property (p_gate_follow) else $error("gate without ack");

	property p_cpu_wait;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!pipeline_stopped_i && !idle_ack_o[`IEG_M_CPU]) |=> !idle_ack_o[`IEG_M_CPU];
	endproperty
	a_cpu_wait: assert property (p_cpu_wait) else $error("cpu idled running");

	property p_reg_wait;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!idle_ack_o[`IEG_M_CPU] |=> !idle_ack_o[`IEG_M_CPUREG];
	endproperty
	a_reg_wait: assert property (p_reg_wait) else $error("cpu regs before cpu");

	property p_dma_free;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_draining ##0 (idle_status_reg_o[`IEG_M_DMA] && !busy_i[`IEG_M_DMA] && !(|bsp_i.dma_req))
			|=> idle_ack_o[`IEG_M_DMA];
	endproperty
	a_dma_free: assert property (p_dma_free) else $error("idle dma late");

	property p_cache_busy;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(busy_i[`IEG_M_INSTRUCTION_CACHE] && !idle_ack_o[`IEG_M_INSTRUCTION_CACHE]) |=> !idle_ack_o[`IEG_M_INSTRUCTION_CACHE];
	endproperty
	a_cache_busy: assert property (p_cache_busy) else $error("cache idled busy");

	property p_cache_free;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_draining ##0 (idle_status_reg_o[`IEG_M_INSTRUCTION_CACHE] && !busy_i[`IEG_M_INSTRUCTION_CACHE])
			|=> idle_ack_o[`IEG_M_INSTRUCTION_CACHE];
	endproperty
	a_cache_free: assert property (p_cache_free) else $error("idle cache late");

	property p_uart_free;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_draining ##0 (idle_status_reg_o[`IEG_M_UART] && !busy_i[`IEG_M_UART])
			|=> idle_ack_o[`IEG_M_UART];
	endproperty
	a_uart_free: assert property (p_uart_free) else $error("idle uart late");

	property p_bsp_busy;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		busy_i[`IEG_M_BSP0] |=> !idle_ack_o[`IEG_M_BSP0];
	endproperty
	a_bsp_busy: assert property (p_bsp_busy) else $error("serial port idled busy");

	property p_dma_wake;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(|bsp_i.dma_req) |=> !idle_ack_o[`IEG_M_DMA];
	endproperty
	a_dma_wake: assert property (p_dma_wake) else $error("dma stayed idle");

	property p_bsp_wake;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		bsp_i.dma_req[0] |=> !idle_ack_o[`IEG_M_BSP0];
	endproperty
	a_bsp_wake: assert property (p_bsp_wake) else $error("serial port stayed idle");

	property p_bsp_quiet;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_draining ##0 (idle_status_reg_o[`IEG_M_BSP1] && !bsp_i.ext_clk[1] &&
			!bsp_i.transmitter_reset_n[1] && !bsp_i.receiver_reset_n[1] &&
			!busy_i[`IEG_M_BSP1] && !bsp_i.dma_req[1]) |=> idle_ack_o[`IEG_M_BSP1];
	endproperty
	a_bsp_quiet: assert property (p_bsp_quiet) else $error("quiet serial port late");

	property p_bsp_rx_refuse;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!bsp_i.ext_clk[1] && bsp_i.receiver_reset_n[1]) |=> !idle_ack_o[`IEG_M_BSP1];
	endproperty
	a_bsp_rx_refuse: assert property (p_bsp_rx_refuse) else $error("receiver idled");

	property p_external_memory_interface_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(busy_i[`IEG_M_DMA] && !idle_ack_o[`IEG_M_DMA] && !idle_ack_o[`IEG_M_EXTERNAL_MEMORY_INTERFACE])
			|=> !idle_ack_o[`IEG_M_EXTERNAL_MEMORY_INTERFACE];
	endproperty
	a_external_memory_interface_hold: assert property (p_external_memory_interface_hold) else $error("external_memory_interface before dma");

endmodule : ieg_idle_gating
`default_nettype wire

/* File: verilog/ieg_pkg.sv */
`default_nettype none
`include "ieg_regs.svh"
package ieg_pkg;
	typedef enum logic [1:0] {
		IEG_RUN    = 2'b00,
		IEG_DRAIN  = 2'b01,
		IEG_IDLE   = 2'b10
	} ieg_state_t;
	// per-module activity and selection vectors
	typedef struct packed {
		logic [`IEG_NMOD-1:0] sel;
		logic [`IEG_NMOD-1:0] busy;
	} ieg_mod_t;
	// serial port configuration
	typedef struct packed {
		logic [`IEG_NBSP-1:0] ext_clk;
		logic [`IEG_NBSP-1:0] transmitter_reset_n;
		logic [`IEG_NBSP-1:0] receiver_reset_n;
		logic [`IEG_NBSP-1:0] dma_req;
	} ieg_bsp_t;
endpackage : ieg_pkg
`default_nettype wire

/* File: verilog/ieg_regs.svh */
`ifndef IEG_REGS_SVH
`define IEG_REGS_SVH
`define IEG_NMOD      16
`define IEG_M_CPU     0
`define IEG_M_CPUREG  1
`define IEG_M_DMA     2
`define IEG_M_HPI     3
`define IEG_M_INSTRUCTION_CACHE  4
`define IEG_M_EXTERNAL_MEMORY_INTERFACE    5
`define IEG_M_TIMER   6
`define IEG_M_WDOG    7
`define IEG_M_OSTICK  8
`define IEG_M_GPIO    9
`define IEG_M_PGPIO   10
`define IEG_M_BSP0    11
`define IEG_M_BSP1    12
`define IEG_M_BSP2    13
`define IEG_M_I2C     14
`define IEG_M_UART    15
`define IEG_NBSP      3
`define IEG_ZERO16    16'h0000
`define IEG_ZERO3     3'h0
`endif
